//--- design/quiet_warn_pkg.sv
// Constants shared by the quiet-timer and motion-warning configuration block.
// Assumes a 200 MHz core clock and a byte-wide register port.
package quiet_warn_pkg;
    // Register offsets
    localparam logic [7:0] QUIET_LEVEL_X_HIGH_ADDR = 8'h2a;
    localparam logic [7:0] QUIET_LEVEL_X_LOW_ADDR = 8'h2b;
    localparam logic [7:0] QUIET_LEVEL_Y_HIGH_ADDR = 8'h2c;
    localparam logic [7:0] QUIET_LEVEL_Y_LOW_ADDR = 8'h2d;
    localparam logic [7:0] QUIET_LEVEL_Z_HIGH_ADDR = 8'h2e;
    localparam logic [7:0] QUIET_LEVEL_Z_LOW_ADDR = 8'h2f;
    localparam logic [7:0] QUIET_TIME_HIGH_ADDR = 8'h30;
    localparam logic [7:0] QUIET_TIME_LOW_ADDR = 8'h31;
    localparam logic [7:0] WARNING_LEVEL_X_HIGH_ADDR = 8'h32;
    localparam logic [7:0] WARNING_LEVEL_X_LOW_CFG_ADDR = 8'h33;
    localparam logic [7:0] WARNING_LEVEL_Y_HIGH_ADDR = 8'h34;
    localparam logic [7:0] WARNING_LEVEL_Y_LOW_CFG_ADDR = 8'h35;
    localparam logic [7:0] WARNING_LEVEL_Z_HIGH_ADDR = 8'h36;
    localparam logic [7:0] WARNING_LEVEL_Z_LOW_CFG_ADDR = 8'h37;
    // Field layout of the low threshold registers
    localparam int LOW_THR_MSB = 7;
    localparam int LOW_THR_LSB = 5;
    localparam int REF_SELECT_BIT = 1;
    localparam int INCLUDE_BIT = 0;
    // Writable bits: threshold, reference select (x only), include
    localparam logic [7:0] LOW_MASK_X = 8'he3;
    localparam logic [7:0] LOW_MASK_YZ = 8'he1;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Data widths
    localparam int SAMPLE_W = 12;
    localparam int LEVEL_W = 11;
    localparam int AXES = 3;
    localparam int TICK_W = 23;
    // Timing: scale of one quiet-time code, and the core clock period
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned QUIET_CODE_SLOW_NS = 32_500_000;
    localparam int unsigned QUIET_CODE_FAST_NS = 16_250_000;
    // Sample-rate code that stands for 5120 Hz; all others are 2560 Hz or lower
    localparam logic [2:0] RATE_5120_CODE = 3'h4;
endpackage

//--- design/level_check_if.sv
// Carries samples, levels and comparison results between the register
// bank and the axis comparator. Assumes one clock domain.
interface level_check_if;
    import quiet_warn_pkg::*;
    logic signed [AXES-1:0][SAMPLE_W-1:0] sample;
    logic signed [AXES-1:0][SAMPLE_W-1:0] ref_sample;
    logic use_ref;
    logic [AXES-1:0][LEVEL_W-1:0] warn_level;
    logic [AXES-1:0][LEVEL_W-1:0] quiet_level;
    logic [AXES-1:0] warn_over;
    logic [AXES-1:0] quiet_below;
    modport bank (output sample, ref_sample, use_ref, warn_level, quiet_level,
                  input warn_over, quiet_below);
    modport check (input sample, ref_sample, use_ref, warn_level, quiet_level,
                   output warn_over, quiet_below);
endinterface

//--- design/axis_level_check.sv
// Combinational per-axis magnitude comparisons for both detectors.
// Assumes samples are two's complement and levels unsigned.
module axis_level_check
    import quiet_warn_pkg::*;
(
    level_check_if.check lc // Samples in, comparison results out
);
    // Magnitude of a signed difference, one bit wider so -2048 is exact
    function automatic logic [SAMPLE_W:0] magnitude(input logic signed [SAMPLE_W:0] v);
        magnitude = v[SAMPLE_W] ? -v : v;
    endfunction

    // Reference mode measures distance from the captured reference
    always_comb begin
        logic signed [SAMPLE_W:0] diff;
        logic [SAMPLE_W:0] mag_warn;
        logic [SAMPLE_W:0] mag_quiet;
        logic signed [SAMPLE_W:0] now_s;
        logic signed [SAMPLE_W:0] ref_s;
        diff = '0;
        mag_warn = '0;
        mag_quiet = '0;
        now_s = '0;
        ref_s = '0;
        for (int a = 0; a < AXES; a++) begin
            // A select of a packed array is unsigned, so restore the sign before widening
            now_s = (SAMPLE_W+1)'($signed(lc.sample[a]));
            ref_s = (SAMPLE_W+1)'($signed(lc.ref_sample[a]));
            diff = lc.use_ref ? now_s - ref_s : now_s;
            mag_warn = magnitude(diff);
            mag_quiet = magnitude(now_s);
            lc.warn_over[a] = mag_warn > (SAMPLE_W+1)'(lc.warn_level[a]);
            lc.quiet_below[a] = mag_quiet < (SAMPLE_W+1)'(lc.quiet_level[a]);
        end
    end
endmodule

//--- design/quiet_timer_motion_warning_cfg.sv
// Register bank and detectors for the inactivity timer and second motion warning.
// Assumes samples arrive as a one-cycle strobe in the core clock domain and that
// the serial register port has already been turned into byte reads and writes.
//
// What this block does
// - Inactivity only after enabled axes stay quiet
// - Quiet time high byte 0x30, low 0x31
// - 32.5 ms per code at 2560 Hz or lower
// - 16.25 ms per code at 5120 Hz
// - Per-axis 11-bit warning level, 100 mg per code
// - Compare sample magnitude against warning level
// - Level bits 10:3 high byte, 2:0 low
// - X low bit 1 selects referenced mode
// - Low bit 0 includes axis in warning
// - Enabled axis above level raises warning
// - All registers reset to zero
// - Quiet low bit 0 includes axis
// - Z warning low bits come from 0x37
module quiet_timer_motion_warning_cfg
    import quiet_warn_pkg::*;
#(
    parameter int unsigned SLOW_CODE_CYCLES = QUIET_CODE_SLOW_NS / CLK_PERIOD_NS,
    parameter int unsigned FAST_CODE_CYCLES = QUIET_CODE_FAST_NS / CLK_PERIOD_NS
) (
    input wire logic core_clk, // Core clock, 200 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [7:0] reg_addr, // Register address
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
    input wire logic [2:0] output_sample_rate, // Current sample-rate code
    input wire logic sample_valid, // One-cycle strobe for a new x/y/z sample
    input wire logic signed [SAMPLE_W-1:0] sample_x, // X acceleration
    input wire logic signed [SAMPLE_W-1:0] sample_y, // Y acceleration
    input wire logic signed [SAMPLE_W-1:0] sample_z, // Z acceleration
    output logic second_motion_detect, // One-cycle motion warning pulse
    output logic quiet_event, // One-cycle inactivity pulse
    output logic quiet_state // High while inactivity holds
);
    generate
        if (SLOW_CODE_CYCLES < 2 || FAST_CODE_CYCLES < 1 || SLOW_CODE_CYCLES >= 2**TICK_W ||
            FAST_CODE_CYCLES > SLOW_CODE_CYCLES) begin : g_bad_cycles
            $error("code cycle counts out of range");
        end
    endgenerate

    typedef struct packed {
        logic [AXES-1:0][7:0] quiet_high;
        logic [AXES-1:0][7:0] quiet_low;
        logic [7:0] quiet_time_high;
        logic [7:0] quiet_time_low;
        logic [AXES-1:0][7:0] warn_high;
        logic [AXES-1:0][7:0] warn_low;
        logic signed [AXES-1:0][SAMPLE_W-1:0] ref_sample;
        logic ref_armed;
        logic quiet_run;
        logic quiet_done;
        logic [TICK_W-1:0] tick;
        logic [15:0] quiet_time_code;
        logic warn_pulse;
        logic quiet_pulse;
        logic [7:0] rdata;
    } state_t;

    state_t cur;
    state_t next_cur;
    level_check_if lc ();

    // Join a high byte and the top three bits of its low partner into a level
    function automatic logic [LEVEL_W-1:0] level_of(input logic [7:0] hi, input logic [7:0] lo);
        level_of = {hi, lo[LOW_THR_MSB:LOW_THR_LSB]};
    endfunction

    // Axis number of an address inside a high/low register pair block
    function automatic int pair_axis(input logic [7:0] addr, input logic [7:0] base);
        pair_axis = int'((addr - base) >> 1);
    endfunction

    axis_level_check u_check (
        .lc(lc)
    );

    // Wire the live samples and decoded levels into the comparator
    always_comb begin
        lc.sample[0] = sample_x;
        lc.sample[1] = sample_y;
        lc.sample[2] = sample_z;
        lc.ref_sample = cur.ref_sample;
        lc.use_ref = cur.warn_low[0][REF_SELECT_BIT];
        for (int a = 0; a < AXES; a++) begin
            lc.warn_level[a] = level_of(cur.warn_high[a], cur.warn_low[a]);
            lc.quiet_level[a] = level_of(cur.quiet_high[a], cur.quiet_low[a]);
        end
    end

    // Next state: register writes and reads, warning check, quiet timer
    always_comb begin
        logic [AXES-1:0] warn_use;
        logic [AXES-1:0] quiet_use;
        logic [15:0] quiet_time_value;
        logic [TICK_W-1:0] code_last;
        warn_use = '0;
        quiet_use = '0;
        quiet_time_value = '0;
        code_last = '0;
        next_cur = cur;
        next_cur.warn_pulse = 1'b0;
        next_cur.quiet_pulse = 1'b0;
        // Include bits of both detectors; an excluded axis never counts
        for (int a = 0; a < AXES; a++) begin
            warn_use[a] = cur.warn_low[a][INCLUDE_BIT];
            quiet_use[a] = cur.quiet_low[a][INCLUDE_BIT];
        end
        // The two byte registers form one 16-bit limit
        quiet_time_value = {cur.quiet_time_high, cur.quiet_time_low};
        // Per-code tick length depends on the sample rate
        if (output_sample_rate == RATE_5120_CODE) begin
            code_last = TICK_W'(FAST_CODE_CYCLES - 1);
        end else begin
            code_last = TICK_W'(SLOW_CODE_CYCLES - 1);
        end

        // Register writes; reserved bits are never stored so they read zero
        if (reg_wr) begin
            if (reg_addr >= QUIET_LEVEL_X_HIGH_ADDR && reg_addr <= QUIET_LEVEL_Z_LOW_ADDR) begin
                if (reg_addr[0] == QUIET_LEVEL_X_HIGH_ADDR[0]) begin
                    next_cur.quiet_high[pair_axis(reg_addr, QUIET_LEVEL_X_HIGH_ADDR)] = reg_wdata;
                end else begin
                    next_cur.quiet_low[pair_axis(reg_addr, QUIET_LEVEL_X_HIGH_ADDR)] =
                        reg_wdata & ((reg_addr == QUIET_LEVEL_X_LOW_ADDR) ? LOW_MASK_X : LOW_MASK_YZ);
                end
            end else if (reg_addr == QUIET_TIME_HIGH_ADDR) begin
                next_cur.quiet_time_high = reg_wdata;
            end else if (reg_addr == QUIET_TIME_LOW_ADDR) begin
                next_cur.quiet_time_low = reg_wdata;
            end else if (reg_addr >= WARNING_LEVEL_X_HIGH_ADDR &&
                         reg_addr <= WARNING_LEVEL_Z_LOW_CFG_ADDR) begin
                if (reg_addr[0] == WARNING_LEVEL_X_HIGH_ADDR[0]) begin
                    next_cur.warn_high[pair_axis(reg_addr, WARNING_LEVEL_X_HIGH_ADDR)] = reg_wdata;
                end else begin
                    next_cur.warn_low[pair_axis(reg_addr, WARNING_LEVEL_X_HIGH_ADDR)] = reg_wdata &
                        ((reg_addr == WARNING_LEVEL_X_LOW_CFG_ADDR) ? LOW_MASK_X : LOW_MASK_YZ);
                end
            end
        end

        // A write and a read in one cycle: the read returns the old byte
        // Register reads; unmapped addresses read zero
        if (reg_rd) begin
            next_cur.rdata = REG_RESET;
            if (reg_addr >= QUIET_LEVEL_X_HIGH_ADDR && reg_addr <= QUIET_LEVEL_Z_LOW_ADDR) begin
                next_cur.rdata = (reg_addr[0] == QUIET_LEVEL_X_HIGH_ADDR[0]) ?
                    cur.quiet_high[pair_axis(reg_addr, QUIET_LEVEL_X_HIGH_ADDR)] :
                    cur.quiet_low[pair_axis(reg_addr, QUIET_LEVEL_X_HIGH_ADDR)];
            end else if (reg_addr == QUIET_TIME_HIGH_ADDR) begin
                next_cur.rdata = cur.quiet_time_high;
            end else if (reg_addr == QUIET_TIME_LOW_ADDR) begin
                next_cur.rdata = cur.quiet_time_low;
            end else if (reg_addr >= WARNING_LEVEL_X_HIGH_ADDR &&
                         reg_addr <= WARNING_LEVEL_Z_LOW_CFG_ADDR) begin
                next_cur.rdata = (reg_addr[0] == WARNING_LEVEL_X_HIGH_ADDR[0]) ?
                    cur.warn_high[pair_axis(reg_addr, WARNING_LEVEL_X_HIGH_ADDR)] :
                    cur.warn_low[pair_axis(reg_addr, WARNING_LEVEL_X_HIGH_ADDR)];
            end
        end

        // Motion warning; in referenced mode the first sample only captures the reference
        // Leaving referenced mode drops the old reference, so a later switch starts clean
        if (!lc.use_ref) begin
            next_cur.ref_armed = 1'b0;
        end
        if (sample_valid) begin
            if (lc.use_ref && !cur.ref_armed) begin
                next_cur.ref_sample = lc.sample;
                next_cur.ref_armed = 1'b1;
            end else if ((lc.warn_over & warn_use) != '0) begin
                next_cur.warn_pulse = 1'b1;
                next_cur.ref_armed = 1'b0; // Re-capture the reference after each warning
            end
        end

        // Quiet timer: restart on any loud enabled axis or with no axis enabled
        if (quiet_use == '0 ||
            (sample_valid && (~lc.quiet_below & quiet_use) != '0)) begin
            next_cur.quiet_run = 1'b0;
            next_cur.quiet_done = 1'b0;
            next_cur.tick = '0;
            next_cur.quiet_time_code = '0;
        end else if (sample_valid && !cur.quiet_run) begin
            // First quiet sample starts the run; later quiet samples let it go on
            next_cur.quiet_run = 1'b1;
        end else if (cur.quiet_run && !cur.quiet_done) begin
            // A lowered limit below the running count still ends the wait
            if (cur.quiet_time_code >= quiet_time_value) begin
                next_cur.quiet_done = 1'b1;
                next_cur.quiet_pulse = 1'b1;
            end else if (cur.tick >= code_last) begin
                next_cur.tick = '0;
                next_cur.quiet_time_code = cur.quiet_time_code + 16'h0001;
            end else begin
                next_cur.tick = cur.tick + TICK_W'(1);
            end
        end
    end

    // State register; everything clears to zero
    // The reset branch loads constants only, so no logic sits in the async path
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs come straight from flip-flops, so they carry no decode glitches
    assign reg_rdata = cur.rdata;
    assign second_motion_detect = cur.warn_pulse;
    assign quiet_event = cur.quiet_pulse;
    assign quiet_state = cur.quiet_done;
endmodule

//--- testbench/host_port_model.sv
// Host model: byte register reads and writes standing for the serial port.
// Assumes the bench calls its tasks after reset has been released.
module host_port_model (
    input wire logic core_clk, // Core clock
    output logic [7:0] reg_addr, // Register address
    output logic reg_wr, // Write strobe
    output logic [7:0] reg_wdata, // Write data
    output logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata // Read data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle until the first request
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One write, strobe held for exactly the taking edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk) #1;
        reg_wr = 1'b0;
        reg_wdata = ~d; // Stale data inverted so it never looks valid
    endtask
    // One read; the byte is valid just after the taking edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk) #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

//--- testbench/quiet_warn_sva.sv
// Checker for the quiet-timer and motion-warning block, top ports only.
// Assumes one core clock; keeps a shadow of the registers from the writes.
module quiet_warn_sva
    import quiet_warn_pkg::*;
#(
    parameter int unsigned SLOW_CODE_CYCLES = 8,
    parameter int unsigned FAST_CODE_CYCLES = 4
) (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic [7:0] reg_addr, // Address
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic [2:0] output_sample_rate, // Rate code
    input wire logic sample_valid, // Sample strobe
    input wire logic signed [SAMPLE_W-1:0] sample_x, // X sample
    input wire logic signed [SAMPLE_W-1:0] sample_y, // Y sample
    input wire logic signed [SAMPLE_W-1:0] sample_z, // Z sample
    input wire logic second_motion_detect, // Warning pulse
    input wire logic quiet_event, // Inactivity pulse
    input wire logic quiet_state // Inactivity level
);
    logic [7:0] shd [14];
    logic [7:0] shd_rd;
    logic [11:0] mag_x;
    logic mapped;
    logic q_none;
    // Reserved bits must read back zero, so the shadow stores only writable bits
    function automatic logic [7:0] wmask(input logic [7:0] a);
        if (!a[0] || a == 8'h31) return 8'hff;
        return (a == 8'h2b || a == 8'h33) ? 8'he3 : 8'he1;
    endfunction
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 14; i++) begin
                shd[i] <= 8'h00;
            end
        end else if (reg_wr && mapped) begin
            shd[4'(reg_addr - 8'h2a)] <= reg_wdata & wmask(reg_addr);
        end
    end
    // Expected read byte, x magnitude and quiet include summary
    assign mapped = reg_addr >= 8'h2a && reg_addr <= 8'h37;
    assign shd_rd = mapped ? shd[4'(reg_addr - 8'h2a)] : 8'h00;
    assign mag_x = sample_x[11] ? 12'(-sample_x) : 12'(sample_x);
    assign q_none = !(shd[1][0] || shd[3][0] || shd[5][0]);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_read_back: assert property (reg_rd |=> reg_rdata == $past(shd_rd))
        else $error("read data differs from the stored byte");
    chk_warn_cause: assert property (second_motion_detect |-> $past(sample_valid))
        else $error("warning without a sample");
    chk_warn_none: assert property (sample_valid && !shd[9][0] && !shd[11][0] && !shd[13][0]
        |=> !second_motion_detect) else $error("warning with no axis included");
    chk_warn_x_abs: assert property (sample_valid && shd[9][0] && !shd[9][1]
        && mag_x > {1'b0, shd[8], shd[9][7:5]} |=> second_motion_detect) else $error("x missed");
    chk_quiet_pulse: assert property (quiet_event |-> quiet_state ##1 !quiet_event)
        else $error("inactivity pulse malformed");
    chk_quiet_rise: assert property ($rose(quiet_state) |-> quiet_event)
        else $error("inactivity level rose without a pulse");
    chk_quiet_drop: assert property ($fell(quiet_state) |->
        $past(sample_valid) || $past(reg_wr, 2))
        else $error("inactivity level fell without a sample");
    chk_quiet_none: assert property (q_none [*3] |-> !quiet_event)
        else $error("inactivity with no axis included");
    cover property (second_motion_detect);
    cover property (quiet_event);
    cover property (reg_rd && reg_addr == 8'h37);
endmodule

bind quiet_timer_motion_warning_cfg quiet_warn_sva #(.SLOW_CODE_CYCLES(SLOW_CODE_CYCLES),
    .FAST_CODE_CYCLES(FAST_CODE_CYCLES)) chk_u (.core_clk, .rst, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .output_sample_rate, .sample_valid, .sample_x,
    .sample_y, .sample_z, .second_motion_detect, .quiet_event, .quiet_state);

//--- testbench/tb_top.sv
// Self-checking bench for the quiet-timer and motion-warning block.
// Assumes short code lengths of 8 and 4 cycles so the timer runs fit in sim.
module tb_top;
    import quiet_warn_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, reg_wr, reg_rd, sample_valid, second_motion_detect;
    logic quiet_event, quiet_state;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] output_sample_rate;
    logic signed [SAMPLE_W-1:0] sample_x, sample_y, sample_z;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    quiet_timer_motion_warning_cfg #(.SLOW_CODE_CYCLES(8), .FAST_CODE_CYCLES(4)) dut_u (
        .core_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .output_sample_rate, .sample_valid, .sample_x, .sample_y, .sample_z,
        .second_motion_detect, .quiet_event, .quiet_state);
    host_port_model host_u (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Hang guard, well above the roughly 3400 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.read_reg(a, d);
        check({8'h00, d}, {8'h00, exp}, "read");
    endtask
    // One x/y/z sample, then the warning pulse is judged in the next cycle
    task automatic warn(input int x, input int y, input int z, input logic exp);
        @(posedge core_clk) #1;
        sample_valid = 1'b1;
        sample_x = 12'(x);
        sample_y = 12'(y);
        sample_z = 12'(z);
        @(posedge core_clk) #1;
        sample_valid = 1'b0;
        sample_x = ~sample_x; // Stale x sample changes so it never looks valid
        check({15'h0, second_motion_detect}, {15'h0, exp}, "warning");
    endtask
    task automatic t_regs();
        logic [7:0] m;
        for (int a = 8'h2a; a <= 8'h38; a++) begin
            rd_chk(8'(a), 8'h00);
            host_u.write_reg(8'(a), 8'hff);
            m = (a[0] && a != 8'h31) ? ((a == 8'h2b || a == 8'h33) ? 8'he3 : 8'he1) : 8'hff;
            rd_chk(8'(a), (a == 8'h38) ? 8'h00 : m);
            host_u.write_reg(8'(a), 8'h00);
        end
    endtask
    task automatic t_warn();
        host_u.write_reg(8'h33, 8'h81); // Level x 4, included, absolute
        host_u.write_reg(8'h34, 8'h01);
        host_u.write_reg(8'h35, 8'h01); // Level y 8, included
        host_u.write_reg(8'h37, 8'h61); // Level z 3, included
        warn(-5, 0, 0, 1'b1);
        warn(4, 0, 0, 1'b0);
        warn(-2048, 0, 0, 1'b1);
        warn(0, 9, 0, 1'b1);
        warn(0, -8, 0, 1'b0);
        warn(0, 0, -4, 1'b1);
        host_u.write_reg(8'h33, 8'h80);
        warn(-5, 0, 0, 1'b0);
        host_u.write_reg(8'h33, 8'h83);
        warn(100, 0, 0, 1'b0);
        warn(100, 0, 0, 1'b0);
        warn(106, 0, 0, 1'b1);
        host_u.write_reg(8'h33, 8'h00);
        host_u.write_reg(8'h35, 8'h00);
        host_u.write_reg(8'h37, 8'h00);
    endtask
    // Quiet run cut short by a loud sample, then a full run timed from its start
    task automatic t_quiet(input logic [2:0] rate, input int n);
        int k;
        output_sample_rate = rate;
        warn(1, 0, 0, 1'b0);
        repeat (50) @(posedge core_clk);
        warn(10, 0, 0, 1'b0); // Equal to the level counts as loud
        warn(1, 0, 0, 1'b0);
        k = 0;
        while (quiet_event !== 1'b1 && k < 4000) begin
            @(posedge core_clk) #1;
            k++;
        end
        check({15'h0, k >= 258 * n && k <= 258 * n + 4}, 16'h1, "quiet time");
        check({15'h0, quiet_state}, 16'h1, "quiet level");
        warn(10, 0, 0, 1'b0);
        check({15'h0, quiet_state}, 16'h0, "quiet drop");
    endtask
    initial begin
        rst = 1'b1;
        output_sample_rate = 3'h0;
        sample_valid = 1'b0;
        sample_x = 12'h000;
        sample_y = 12'h000;
        sample_z = 12'h000;
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        t_regs();
        t_warn();
        host_u.write_reg(8'h2a, 8'h01);
        host_u.write_reg(8'h2b, 8'h41); // Quiet level x 10, included
        host_u.write_reg(8'h30, 8'h01);
        host_u.write_reg(8'h31, 8'h02); // Quiet time 258 codes
        t_quiet(3'h0, 8);
        t_quiet(3'h4, 4);
        wrap_up();
    end
endmodule
